//--- ecp_rev_defs.svh
// timing counts, pad byte and block limit for the ecp reverse data handshake
`ifndef ECP_REV_DEFS_SVH
`define ECP_REV_DEFS_SVH
`define ECP_REV_CLK_HZ 10000000
`define ECP_REV_TURN_MIN_SCLK 5
`define ECP_REV_TURN_MAX_SCLK 8
`define ECP_REV_ACK_MIN_SCLK 3
`define ECP_REV_ACK_MAX_SCLK 4
`define ECP_REV_REL_MAX_SCLK 3
`define ECP_REV_FETCH_MAX_BCLK 13
`define ECP_REV_HOST_SETUP_NS 50
`define ECP_REV_HOST_SETUP_CYC ((`ECP_REV_HOST_SETUP_NS * (`ECP_REV_CLK_HZ / 1000000) + 999) / 1000)
`define ECP_REV_HOST_HANDBACK_NS 500
`define ECP_REV_HOST_HANDBACK_CYC ((`ECP_REV_HOST_HANDBACK_NS * (`ECP_REV_CLK_HZ / 1000000) + 999) / 1000)
`define ECP_REV_HOST_ACCEPT_S 1
`define ECP_REV_HOST_ACCEPT_CYC (`ECP_REV_HOST_ACCEPT_S * `ECP_REV_CLK_HZ)
`define ECP_REV_PAD_BYTE 8'h00
`define ECP_REV_MAX_BLOCK 16
`endif

//--- ecp_rev_pkg.sv
// shared types for the ecp reverse data handshake
package ecp_rev_pkg;
	typedef enum logic [2:0] {
		DEV_FWD, DEV_TURN, DEV_FETCH, DEV_ACK_WAIT, DEV_ACK_LOW, DEV_ACK_RISE, DEV_BYTE_END,
		DEV_RELEASE
	} dev_state_t;
	typedef enum logic [2:0] {
		HOST_FWD, HOST_REQ, HOST_WAIT_PE, HOST_WAIT_ACK, HOST_SETUP, HOST_WAIT_RISE,
		HOST_ACCEPT, HOST_HANDBACK
	} host_state_t;
endpackage

//--- ecp_rev_if.sv
// parallel port lines between peripheral and host
`timescale 1ns/10ps
interface ecp_rev_if;
	logic host_init_line_n;
	logic host_autofeed_line_n;
	logic paper_error_line;
	logic peripheral_ack_line_n;
	logic busy_indicator;
	logic fault_hint_line_n;
	logic [7:0] dev_data_o;
	logic dev_data_oe;
	logic [7:0] host_data_o;
	logic host_data_oe;
	logic [7:0] port_data_lines;
	// wire level resolved from the two enables; contention reads as the device value
	assign port_data_lines = dev_data_oe ? dev_data_o : (host_data_oe ? host_data_o : 8'hff);
	modport device (
		input host_init_line_n, host_autofeed_line_n, port_data_lines,
		output paper_error_line, peripheral_ack_line_n, busy_indicator, fault_hint_line_n,
		output dev_data_o, dev_data_oe
	);
	modport host (
		output host_init_line_n, host_autofeed_line_n, host_data_o, host_data_oe,
		input paper_error_line, peripheral_ack_line_n, busy_indicator, fault_hint_line_n,
		input port_data_lines
	);
endinterface

//--- ecp_rev_device.sv
// peripheral end: reverse data engine with a two-entry byte buffer
`timescale 1ns/10ps
`include "ecp_rev_defs.svh"
module ecp_rev_device
	import ecp_rev_pkg::*;
#(
	parameter int DEPTH = 2,
	parameter int MAX_BLOCK = `ECP_REV_MAX_BLOCK,
	parameter int BCLK_DIV = 2
) (
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	ecp_rev_if.device PORT,
	input wire logic [7:0] SRC_DATA_IN,
	input wire logic SRC_VALID_IN,
	output logic SRC_READY_OUT,
	output logic REVERSE_ACTIVE_OUT,
	output logic PAD_ACTIVE_OUT
);
	localparam int CW = 5;
	localparam int FETCH_CYC = `ECP_REV_FETCH_MAX_BCLK * BCLK_DIV;
	typedef struct packed {
		logic [1:0] init_s;
		logic [1:0] alf_s;
		dev_state_t st;
		logic [CW-1:0] cnt;
		logic [7:0] buf0;
		logic [7:0] buf1;
		logic [1:0] fill;
		logic [15:0] sent;
		logic pe;
		logic ack_n;
		logic busy;
		logic [7:0] dout;
		logic oe;
		logic src_ready;
		logic pad_r;
	} dev_s_t;
	dev_s_t s_reg;
	dev_s_t s_next;
	logic init_on;
	logic alf_on;
	logic have_byte;
	logic [7:0] head;
	logic pad;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.init_s = {s_reg.init_s[0], ~PORT.host_init_line_n};
		s_next.alf_s = {s_reg.alf_s[0], ~PORT.host_autofeed_line_n};
		init_on = s_reg.init_s[1];
		alf_on = s_reg.alf_s[1];
		pad = (s_reg.sent >= 16'(MAX_BLOCK));
		have_byte = pad || (s_reg.fill != 2'd0);
		head = pad ? `ECP_REV_PAD_BYTE : s_reg.buf0;
		// two-entry buffer fill from the source
		if (SRC_VALID_IN && s_reg.src_ready && !pad) begin
			if (s_reg.fill == 2'd0)
				s_next.buf0 = SRC_DATA_IN;
			else
				s_next.buf1 = SRC_DATA_IN;
			s_next.fill = s_reg.fill + 2'd1;
		end
		if (s_reg.cnt != '0)
			s_next.cnt = s_reg.cnt - CW'(1);
		if (!init_on && s_reg.st != DEV_FWD && s_reg.st != DEV_RELEASE) begin
			// abort on forward request
			// zero count: release lands four clocks after init is let go
			s_next.st = DEV_RELEASE;
			s_next.cnt = CW'(`ECP_REV_ACK_MIN_SCLK - 3);
		end else begin
			unique case (s_reg.st)
				DEV_FWD: begin
					// both synced host lines asserted before turning the bus
					if (init_on && alf_on) begin
						s_next.st = DEV_TURN;
						s_next.cnt = CW'(`ECP_REV_TURN_MIN_SCLK - 3);
					end
				end
				DEV_TURN: begin
					if (s_reg.cnt == '0) begin
						s_next.pe = 1'b0;
						s_next.oe = 1'b1;
						s_next.dout = 8'hff;
						s_next.sent = '0;
						s_next.st = DEV_FETCH;
						s_next.cnt = CW'(FETCH_CYC);
					end
				end
				DEV_FETCH: begin
					// buffered byte or pad placed as soon as one is ready; the fetch count is never checked
					if (have_byte) begin
						s_next.dout = head;
						s_next.busy = 1'b1;
						s_next.st = DEV_ACK_WAIT;
						s_next.cnt = CW'(`ECP_REV_ACK_MIN_SCLK - 1);
					end
				end
				DEV_ACK_WAIT: begin
					if (s_reg.cnt == '0) begin
						s_next.ack_n = 1'b0;
						s_next.st = DEV_ACK_LOW;
					end
				end
				DEV_ACK_LOW: begin
					if (!alf_on) begin
						s_next.st = DEV_ACK_RISE;
						s_next.cnt = CW'(`ECP_REV_ACK_MIN_SCLK - 3);
					end
				end
				DEV_ACK_RISE: begin
					if (s_reg.cnt == '0) begin
						s_next.ack_n = 1'b1;
						if (!pad) begin
							s_next.buf0 = s_reg.buf1;
							s_next.fill = s_next.fill - 2'd1;
						end
						// saturate so a long pad run never wraps back to data
						if (s_reg.sent != 16'hffff)
							s_next.sent = s_reg.sent + 16'd1;
						s_next.st = DEV_BYTE_END;
					end
				end
				DEV_BYTE_END: begin
					if (alf_on) begin
						s_next.st = DEV_FETCH;
						s_next.dout = 8'hff;
					end
				end
				DEV_RELEASE: begin
					if (s_reg.cnt == '0) begin
						s_next.oe = 1'b0;
						s_next.busy = 1'b0;
						s_next.ack_n = 1'b1;
						s_next.pe = 1'b1;
						s_next.st = DEV_FWD;
					end
				end
			endcase
		end

		// ----------------------------------------
		// flags that follow the next state
		// ----------------------------------------
		s_next.pad_r = (s_next.sent >= 16'(MAX_BLOCK));
		// source refused when full, forward or padding
		s_next.src_ready = (s_next.fill < 2'(DEPTH)) && (s_next.st != DEV_FWD)
			&& !s_next.pad_r;
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			s_reg <= '{
				init_s: 2'b00,
				alf_s: 2'b00,
				st: DEV_FWD,
				cnt: '0,
				buf0: 8'h00,
				buf1: 8'h00,
				fill: 2'd0,
				sent: 16'h0000,
				pe: 1'b1,
				ack_n: 1'b1,
				busy: 1'b0,
				dout: 8'h00,
				oe: 1'b0,
				src_ready: 1'b0,
				pad_r: 1'b0
			};
		end else begin
			s_reg <= s_next;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign PORT.paper_error_line = s_reg.pe;
	assign PORT.peripheral_ack_line_n = s_reg.ack_n;
	assign PORT.busy_indicator = s_reg.busy;
	assign PORT.fault_hint_line_n = 1'b1;
	assign PORT.dev_data_o = s_reg.dout;
	assign PORT.dev_data_oe = s_reg.oe;
	assign SRC_READY_OUT = s_reg.src_ready;
	assign REVERSE_ACTIVE_OUT = s_reg.oe;
	assign PAD_ACTIVE_OUT = s_reg.pad_r;
endmodule

//--- ecp_rev_host.sv
// host end: requests reversal, reads bytes, hands the bus back
`timescale 1ns/10ps
`include "ecp_rev_defs.svh"
module ecp_rev_host
	import ecp_rev_pkg::*;
#(
	parameter int ACCEPT_CYC = 8
) (
	input wire logic MCLK_IN,
	input wire logic NRST_IN,
	ecp_rev_if.host PORT,
	input wire logic REVERSE_REQ_IN,
	input wire logic SINK_READY_IN,
	output logic [7:0] SINK_DATA_OUT,
	output logic SINK_VALID_OUT,
	output logic REVERSED_OUT
);
	typedef struct packed {
		logic [1:0] pe_s;
		logic [1:0] ack_s;
		logic [7:0] d_s1;
		logic [7:0] d_s2;
		host_state_t st;
		logic [7:0] cnt;
		logic init_n;
		logic alf_n;
		logic oe;
		logic [7:0] data;
		logic valid;
		logic rev;
	} host_s_t;
	host_s_t s_reg;
	host_s_t s_next;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_next = s_reg;
		s_next.pe_s = {s_reg.pe_s[0], PORT.paper_error_line};
		s_next.ack_s = {s_reg.ack_s[0], PORT.peripheral_ack_line_n};
		s_next.d_s1 = PORT.port_data_lines;
		s_next.d_s2 = s_reg.d_s1;
		if (s_reg.valid && SINK_READY_IN)
			s_next.valid = 1'b0;
		if (s_reg.cnt != 8'h00)
			s_next.cnt = s_reg.cnt - 8'h01;
		// fault line is deliberately never read
		unique case (s_reg.st)
			HOST_FWD: begin
				if (REVERSE_REQ_IN) begin
					s_next.oe = 1'b0;
					s_next.alf_n = 1'b0;
					s_next.st = HOST_REQ;
				end
			end
			HOST_REQ: begin
				s_next.init_n = 1'b0;
				s_next.st = HOST_WAIT_PE;
			end
			HOST_WAIT_PE: begin
				if (!s_reg.pe_s[1]) begin
					s_next.rev = 1'b1;
					s_next.st = HOST_WAIT_ACK;
				end
			end
			HOST_WAIT_ACK: begin
				if (!REVERSE_REQ_IN) begin
					s_next.init_n = 1'b1;
					s_next.st = HOST_HANDBACK;
				end else if (!s_reg.ack_s[1] && !s_reg.valid) begin
					s_next.st = HOST_SETUP;
					s_next.cnt = 8'(`ECP_REV_HOST_SETUP_CYC);
				end
			end
			HOST_SETUP: begin
				if (s_reg.cnt == 8'h00) begin
					s_next.alf_n = 1'b1;
					s_next.st = HOST_WAIT_RISE;
				end
			end
			HOST_WAIT_RISE: begin
				if (s_reg.ack_s[1]) begin
					s_next.data = s_reg.d_s2;
					s_next.valid = 1'b1;
					s_next.st = HOST_ACCEPT;
					s_next.cnt = 8'(ACCEPT_CYC);
				end
			end
			HOST_ACCEPT: begin
				if (s_reg.cnt == 8'h00) begin
					s_next.alf_n = 1'b0;
					s_next.st = HOST_WAIT_ACK;
				end
			end
			HOST_HANDBACK: begin
				if (s_reg.pe_s[1]) begin
					s_next.oe = 1'b1;
					s_next.alf_n = 1'b1;
					s_next.rev = 1'b0;
					s_next.st = HOST_FWD;
				end
			end
		endcase
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge MCLK_IN or negedge NRST_IN) begin
		if (!NRST_IN) begin
			s_reg <= '{pe_s: 2'b11, ack_s: 2'b11, d_s1: 8'h00, d_s2: 8'h00, st: HOST_FWD,
				cnt: 8'h00, init_n: 1'b1, alf_n: 1'b1, oe: 1'b1, data: 8'h00,
				valid: 1'b0, rev: 1'b0};
		end else begin
			s_reg <= s_next;
		end
	end

	assign PORT.host_init_line_n = s_reg.init_n;
	assign PORT.host_autofeed_line_n = s_reg.alf_n;
	assign PORT.host_data_o = 8'h00;
	assign PORT.host_data_oe = s_reg.oe;
	assign SINK_DATA_OUT = s_reg.data;
	assign SINK_VALID_OUT = s_reg.valid;
	assign REVERSED_OUT = s_reg.rev;
endmodule

//--- ecp_rev_chk.sv
// line checks between the peripheral and host ends
`timescale 1ns/10ps
module ecp_rev_chk (
	input logic MCLK_IN,
	input logic NRST_IN,
	input logic host_init_line_n,
	input logic host_autofeed_line_n,
	input logic paper_error_line,
	input logic peripheral_ack_line_n,
	input logic busy_indicator,
	input logic fault_hint_line_n,
	input logic dev_data_oe,
	input logic host_data_oe,
	input logic [7:0] port_data_lines
);
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!NRST_IN);
	AST_NO_HINT: assert property (fault_hint_line_n) else $error("fault low");
	AST_ACK_BUSY: assert property (!peripheral_ack_line_n |-> busy_indicator) else $error("no busy");
	AST_HOST_ORDER: assert property ($fell(host_init_line_n) |-> !host_autofeed_line_n && !host_data_oe)
		else $error("bad request order");
	AST_TURN: assert property ($fell(host_init_line_n) |-> paper_error_line[*5] ##[1:4] !paper_error_line)
		else $error("turn time");
	AST_DRIVE: assert property (!paper_error_line |-> dev_data_oe) else $error("not driving");
	AST_ACK_FALL: assert property ($rose(busy_indicator) |-> ##[3:4] $fell(peripheral_ack_line_n))
		else $error("ack fall time");
	AST_ACK_RISE: assert property ($rose(host_autofeed_line_n) && !peripheral_ack_line_n
		|-> ##[3:4] $rose(peripheral_ack_line_n)) else $error("ack rise time");
	AST_DATA_HOLD: assert property (!peripheral_ack_line_n |-> $stable(port_data_lines))
		else $error("data moved");
	AST_RELEASE: assert property ($rose(host_init_line_n) |-> ##[3:4] !dev_data_oe && !busy_indicator)
		else $error("release time");
	AST_PE_BACK: assert property ($fell(dev_data_oe) |-> ##[0:3] paper_error_line)
		else $error("pe late");
	AST_HOST_WAIT: assert property (host_data_oe |-> paper_error_line) else $error("host early");
	cover property ($fell(paper_error_line));
	cover property ($rose(peripheral_ack_line_n));
	cover property ($rose(host_init_line_n));
endmodule

//--- ecp_reverse_data_handshake_test.sv
// self-checking bench for both ends of the reverse data handshake
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
`define WAITFOR(c) begin n = 0; while (!(c) && n < 300) begin @(negedge mclk); n++; end \
	if (n >= 300) begin bad_count++; conclude(); end end
module ecp_reverse_data_handshake_test import ecp_rev_pkg::*; ;
	logic mclk, nrst, src_valid, req, sink_ready, ok;
	logic src_ready, rev_active, pad_active, sink_valid, reversed;
	logic [7:0] src_data, sink_data;
	logic [7:0] q[$];
	int bad_count, check_count, n, k;
	ecp_rev_if i_ecp_rev_if();
	ecp_rev_device #(.MAX_BLOCK(8)) i_ecp_rev_device (.MCLK_IN(mclk), .NRST_IN(nrst),
		.PORT(i_ecp_rev_if.device), .SRC_DATA_IN(src_data), .SRC_VALID_IN(src_valid),
		.SRC_READY_OUT(src_ready), .REVERSE_ACTIVE_OUT(rev_active), .PAD_ACTIVE_OUT(pad_active));
	ecp_rev_host i_ecp_rev_host (.MCLK_IN(mclk), .NRST_IN(nrst), .PORT(i_ecp_rev_if.host),
		.REVERSE_REQ_IN(req), .SINK_READY_IN(sink_ready), .SINK_DATA_OUT(sink_data),
		.SINK_VALID_OUT(sink_valid), .REVERSED_OUT(reversed));
	ecp_rev_chk i_ecp_rev_chk (.MCLK_IN(mclk), .NRST_IN(nrst),
		.host_init_line_n(i_ecp_rev_if.host_init_line_n),
		.host_autofeed_line_n(i_ecp_rev_if.host_autofeed_line_n),
		.paper_error_line(i_ecp_rev_if.paper_error_line),
		.peripheral_ack_line_n(i_ecp_rev_if.peripheral_ack_line_n),
		.busy_indicator(i_ecp_rev_if.busy_indicator),
		.fault_hint_line_n(i_ecp_rev_if.fault_hint_line_n),
		.dev_data_oe(i_ecp_rev_if.dev_data_oe), .host_data_oe(i_ecp_rev_if.host_data_oe),
		.port_data_lines(i_ecp_rev_if.port_data_lines));
	always #50 mclk = ~mclk;
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task conclude;
		if (bad_count == 0 && check_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// source push; a refusal after 40 cycles returns ok low
	task try_push(input logic [7:0] d);
		@(negedge mclk);
		src_data = d;
		src_valid = 1'b1;
		n = 0;
		while (src_ready !== 1'b1 && n < 40) begin
			@(negedge mclk);
			n++;
		end
		ok = (n < 40);
		if (ok) begin
			q.push_back(d);
			@(negedge mclk);
		end
		src_valid = 1'b0;
	endtask
	task pull(input logic [7:0] d);
		`WAITFOR(sink_valid === 1'b1)
		`CHK(sink_data, d)
		@(negedge mclk);
	endtask
	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		mclk = 0; nrst = 0; src_data = 8'h00; src_valid = 0; req = 0; sink_ready = 1;
		bad_count = 0; check_count = 0;
		repeat (4) @(negedge mclk);
		nrst = 1;
		@(negedge mclk);
		`CHK(src_ready, 1'b0)
		`CHK(i_ecp_rev_if.fault_hint_line_n, 1'b1)
		req = 1'b1;
		`WAITFOR(rev_active === 1'b1)
		`CHK(i_ecp_rev_if.paper_error_line, 1'b0)
		// receiver stalled: fill until refused
		sink_ready = 1'b0;
		ok = 1'b1;
		while (ok && q.size() < 8) try_push(8'h10 + 8'(q.size()));
		k = q.size();
		`CHK(reversed, 1'b1)
		`CHK(k > 1, 1'b1)
		sink_ready = 1'b1;
		while (q.size() > 0) pull(q.pop_front());
		for (int i = k; i < 8; i++) begin
			try_push(8'ha0 + 8'(i));
			pull(q.pop_front());
		end
		repeat (2) pull(8'h00);
		`CHK(pad_active, 1'b1)
		`CHK(src_ready, 1'b0)
		// hand back while padding, between pad bytes
		req = 1'b0;
		`WAITFOR(i_ecp_rev_if.paper_error_line === 1'b1)
		`CHK({i_ecp_rev_if.dev_data_oe, i_ecp_rev_if.busy_indicator, rev_active}, 3'h0)
		req = 1'b1;
		`WAITFOR(rev_active === 1'b1)
		`CHK(pad_active, 1'b0)
		try_push(8'hc3);
		pull(q.pop_front());
		nrst = 1'b0;
		@(negedge mclk);
		`CHK({i_ecp_rev_if.paper_error_line, i_ecp_rev_if.dev_data_oe, reversed}, 3'h4)
		nrst = 1'b1;
		repeat (4) @(negedge mclk);
		conclude();
	end
endmodule
